// file: rtl/stp_device.sv
/*
  Serial control and status end of a two-coil stepper driver.
  Assumes the link pins are asynchronous to sys_clk; pwm_tick, osc_tick,
  oc_hit and pwm_off are one-cycle pulses from chopper logic on sys_clk.
*/
// The strobed register port and the placing of the registers were left to the implementer.
// Overview of operation
// - Sample input on rising, shift output after falling
// - Both words travel most significant bit first
// - Master gives at least twelve clocks
// - Extra bits emerge twelve clocks later
// - Chip select rise loads command register
// - Last twelve bits form the command
// - Enable held low while link used
// - Command bit fields per bridge
// - Decay one mixed; direction zero forward
// - Status word layout with constant one
// - Overcurrent: three hits in 63 cycles
// - Open load after fifteen idle oscillator cycles
// - Open load reads active during faults
// - Zero current: chopper off, open load zero
// - Both zero: clear overcurrent, enter standby
// - Reset or disable clears all registers
// - Current code is linear sixteenths
// - Logic undervoltage forces standby
// - Standby: gates off, then oscillator off
// - Software checks open load at low speed
// - Data out released when deselected
// - Short transfers are discarded
`timescale 1ns/1ps
`default_nettype none
module stp_device (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  stp_link_if.dev         lnk,
  input  wire logic [2:0] load_level_in,
  input  wire logic       overtemp_in,
  input  wire logic       prewarn_in,
  input  wire logic       vs_low_in,
  input  wire logic       vcc_low_in,
  input  wire logic       pwm_tick,
  input  wire logic [2:0] oc_hit,
  input  wire logic       osc_tick,
  input  wire logic [1:0] pwm_off,
  output logic            mixed_decay_a,
  output logic [3:0]      coil_current_a,
  output logic            bridge_a_direction,
  output logic            mixed_decay_b,
  output logic [3:0]      coil_current_b,
  output logic            bridge_b_direction,
  output logic [1:0]      chopper_on,
  output logic            gate_drive_en,
  output logic            osc_enable,
  output logic            standby
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [11:0] sync_q;
  logic        sck_s;
  logic        sdi_s;
  logic        csn_s;
  logic        enn_s;
  logic        ot_s;
  logic        temp_prewarning_s;
  logic        uv_s;
  logic        vcc_low_s;
  logic [2:0]  load_s;

  stp_sync #(.W(11), .RST(32'h0180)) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .d       ({lnk.sck, lnk.sdi, lnk.chip_select_n, lnk.device_enable_n, overtemp_in,
               prewarn_in, vs_low_in, vcc_low_in, load_level_in}),
    .q       (sync_q[10:0])
  );

  assign sync_q[11] = 1'b0;
  assign {sck_s, sdi_s, csn_s, enn_s, ot_s, temp_prewarning_s, uv_s, vcc_low_s} = sync_q[10:3];
  assign load_s = sync_q[2:0];

  // ------------------------------------------------------------
  // Edge detection
  // ------------------------------------------------------------
  logic sck_d_reg;
  logic csn_d_reg;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_d_reg <= 1'b0;
      csn_d_reg <= 1'b1;
    end
    else
    begin
      sck_d_reg <= sck_s;
      csn_d_reg <= csn_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d_reg & ~csn_s & ~enn_s;
  assign sck_fall = ~sck_s & sck_d_reg & ~csn_s & ~enn_s;
  assign cs_fall  = ~csn_s & csn_d_reg & ~enn_s;
  assign cs_rise  = csn_s & ~csn_d_reg & ~enn_s;

  // ------------------------------------------------------------
  // Shift register, bit count and data out
  // ------------------------------------------------------------
  logic [11:0] shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic [11:0] status_word;
  logic        sdo_reg;
  logic        sdo_oe_reg;
  logic [2:0]  oc_flag_reg;
  logic [1:0]  ol_flag;

  assign status_word = {load_s, 1'b1, ot_s, temp_prewarning_s, uv_s, oc_flag_reg[2],
                        ol_flag[1], ol_flag[0], oc_flag_reg[1], oc_flag_reg[0]};

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      shift_reg <= stp_pkg::CMD_RESET;
    else if (enn_s)
      shift_reg <= stp_pkg::CMD_RESET;
    else if (cs_fall)
      shift_reg <= status_word;
    else if (sck_rise)
      shift_reg <= {shift_reg[10:0], sdi_s};
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      bit_cnt_reg <= 4'h0;
    else if (enn_s || cs_fall)
      bit_cnt_reg <= 4'h0;
    else if (sck_rise && bit_cnt_reg != stp_pkg::BITS_FULL)
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end
    else
    begin
      sdo_oe_reg <= ~csn_s & ~enn_s;
      if (enn_s)
        sdo_reg <= 1'b0;
      else if (cs_fall)
        sdo_reg <= status_word[11];
      else if (sck_fall)
        sdo_reg <= shift_reg[11];
    end
  end

  assign lnk.sdo    = sdo_reg;
  assign lnk.sdo_oe = sdo_oe_reg;

  // ------------------------------------------------------------
  // Command register and standby sequencing
  // ------------------------------------------------------------
  logic [11:0] cmd_reg;
  logic        cmd_take;
  logic        both_zero_take;
  logic        standby_now;

  assign cmd_take = cs_rise && bit_cnt_reg == stp_pkg::BITS_FULL;
  assign both_zero_take = cmd_take && shift_reg[10:7] == stp_pkg::CUR_OFF
                          && shift_reg[4:1] == stp_pkg::CUR_OFF;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      cmd_reg <= stp_pkg::CMD_RESET;
    else if (enn_s)
      cmd_reg <= stp_pkg::CMD_RESET;
    else if (cmd_take)
      cmd_reg <= shift_reg;
  end

  // Current codes go out unchanged as sixteenth-step DAC settings.
  assign mixed_decay_a      = cmd_reg[stp_pkg::MD_A_BIT];
  assign coil_current_a     = cmd_reg[stp_pkg::CUR_A_LSB +: 4];
  assign bridge_a_direction = cmd_reg[stp_pkg::DIR_A_BIT];
  assign mixed_decay_b      = cmd_reg[stp_pkg::MD_B_BIT];
  assign coil_current_b     = cmd_reg[stp_pkg::CUR_B_LSB +: 4];
  assign bridge_b_direction = cmd_reg[stp_pkg::DIR_B_BIT];

  assign standby_now = enn_s | vcc_low_s
                       | (coil_current_a == stp_pkg::CUR_OFF
                          && coil_current_b == stp_pkg::CUR_OFF);

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      standby       <= 1'b1;
      gate_drive_en <= 1'b0;
      osc_enable    <= 1'b0;
      chopper_on    <= 2'b00;
    end
    else
    begin
      standby       <= standby_now;
      gate_drive_en <= ~standby_now;
      // Oscillator stops only once the gates were already off a cycle.
      osc_enable    <= ~standby_now | gate_drive_en;
      chopper_on[0] <= ~standby_now && coil_current_a != stp_pkg::CUR_OFF;
      chopper_on[1] <= ~standby_now && coil_current_b != stp_pkg::CUR_OFF;
    end
  end

  // ------------------------------------------------------------
  // Overcurrent flags: low side A, low side B, high side
  // ------------------------------------------------------------
  logic [5:0] win_reg;
  logic       win_end;

  assign win_end = pwm_tick && win_reg == stp_pkg::OC_WIN_LAST;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      win_reg <= 6'h00;
    else if (enn_s || win_end)
      win_reg <= 6'h00;
    else if (pwm_tick)
      win_reg <= win_reg + 6'h01;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_oc
      logic [1:0] hits_reg;
      logic       hit;
      logic       set_flag;

      assign hit      = pwm_tick & oc_hit[gi];
      assign set_flag = hit && hits_reg == 2'(stp_pkg::OC_HITS - 1);

      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
          hits_reg <= 2'h0;
        else if (enn_s || win_end)
          hits_reg <= 2'h0;
        else if (hit && hits_reg != 2'(stp_pkg::OC_HITS - 1))
          hits_reg <= hits_reg + 2'h1;
      end

      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
          oc_flag_reg[gi] <= 1'b0;
        else if (enn_s)
          oc_flag_reg[gi] <= 1'b0;
        else if (set_flag)
          oc_flag_reg[gi] <= 1'b1;
        else if (both_zero_take)
          oc_flag_reg[gi] <= 1'b0;
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Open load detection per bridge
  // ------------------------------------------------------------
  logic [1:0] cur_on;

  assign cur_on = {coil_current_b != stp_pkg::CUR_OFF, coil_current_a != stp_pkg::CUR_OFF};

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ol
      logic [3:0] idle_reg;

      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
          idle_reg <= 4'h0;
        else if (enn_s || !cur_on[gi] || pwm_off[gi])
          idle_reg <= 4'h0;
        else if (osc_tick && idle_reg <= stp_pkg::OL_LIMIT)
          idle_reg <= idle_reg + 4'h1;
      end

      assign ol_flag[gi] = cur_on[gi]
                           && (idle_reg > stp_pkg::OL_LIMIT
                               || |oc_flag_reg || uv_s || ot_s);
    end
  endgenerate
endmodule : stp_device
`default_nettype wire

// file: rtl/stp_pkg.sv
/*
  Shared constants of the stepper driver serial link: word layout, counts, timing.
  Assumes a 100 MHz system clock on both ends.
*/
package stp_pkg;
  localparam int          CMD_W        = 12;
  localparam logic [11:0] CMD_RESET    = 12'h000;
  localparam int          MD_A_BIT     = 11;
  localparam int          CUR_A_LSB    = 7;
  localparam int          DIR_A_BIT    = 6;
  localparam int          MD_B_BIT     = 5;
  localparam int          CUR_B_LSB    = 1;
  localparam int          DIR_B_BIT    = 0;
  localparam logic [3:0]  CUR_OFF      = 4'h0;
  localparam logic [3:0]  BITS_FULL    = 4'hC;
  localparam int          OC_HITS      = 3;
  localparam logic [5:0]  OC_WIN_LAST  = 6'h3E;
  localparam logic [3:0]  OL_LIMIT     = 4'hE;
  localparam int          CLK_NS       = 10;
  localparam int          SCK_HALF_NS  = 100;
  localparam int          SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int          EN_SETUP_NS  = 30000;
  localparam int          EN_SETUP_CYC = (EN_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_CMD     = 4'h4;
  localparam logic [3:0]  ADDR_STAT    = 4'h8;
  localparam logic [3:0]  ADDR_RX      = 4'hC;
  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_DONE    = 1;
  localparam int          STAT_READY   = 2;
endpackage : stp_pkg

// file: rtl/stp_link_if.sv
/*
  Serial link between the controller and the stepper driver.
  The data-out wire idles high when the driver does not drive it.
*/
`timescale 1ns/1ps
`default_nettype none
interface stp_link_if;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic chip_select_n;
  logic device_enable_n;
  logic sdo_line;

  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev  (input sck, sdi, chip_select_n, device_enable_n, output sdo, sdo_oe);
  modport host (output sck, sdi, chip_select_n, device_enable_n, input sdo_line);
endinterface : stp_link_if
`default_nettype wire

// file: rtl/stp_sync.sv
/*
  Two-flop synchroniser for a group of independent levels.
  Assumes each bit is a slow level or a clock far below sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module stp_sync #(
  parameter int          W   = 1,
  parameter logic [31:0] RST = 32'h0
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_reg <= RST[W-1:0];
      q        <= RST[W-1:0];
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : stp_sync
`default_nettype wire

// file: rtl/stp_host.sv
/*
  Controller end of the stepper driver link: a serial master with a register port.
  Assumes software on sys_clk; reads return data one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module stp_host #(
  parameter int BITS     = stp_pkg::CMD_W,
  parameter int HALF_CYC = stp_pkg::SCK_HALF_CYC,
  parameter int EN_CYC   = stp_pkg::EN_SETUP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  stp_link_if.host         lnk,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata
);
  if (BITS < stp_pkg::CMD_W || BITS > 32 || HALF_CYC < 4 || HALF_CYC > 65536
      || EN_CYC < 1 || EN_CYC > 65535)
  begin : g_param_check
    $error("stp_host: unsupported parameters");
  end

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_LEAD  = 5'b00010,
    ST_LOW   = 5'b00100,
    ST_HIGH  = 5'b01000,
    ST_TRAIL = 5'b10000
  } stp_host_state_type;

  // ------------------------------------------------------------
  // Registers and link state
  // ------------------------------------------------------------
  stp_host_state_type state_reg;
  logic [BITS-1:0]    tx_reg;
  logic [BITS-1:0]    rx_reg;
  logic [BITS-1:0]    rx_word_reg;
  logic [5:0]         bit_reg;
  logic [15:0]        tmr_reg;
  logic [15:0]        en_wait_reg;
  logic               en_reg;
  logic               done_reg;
  logic               sck_reg;
  logic               sdi_reg;
  logic               csn_reg;
  logic               sdo_s;
  logic               tmr_end;
  logic               start;

  stp_sync #(.W(1), .RST(32'h1)) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .d       (lnk.sdo_line),
    .q       (sdo_s)
  );

  assign tmr_end = tmr_reg == 16'h0;
  assign start   = wr && addr == stp_pkg::ADDR_CMD && state_reg == ST_IDLE
                   && en_reg && en_wait_reg == 16'h0;

  assign lnk.sck             = sck_reg;
  assign lnk.sdi             = sdi_reg;
  assign lnk.chip_select_n   = csn_reg;
  assign lnk.device_enable_n = ~en_reg;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      en_reg      <= 1'b0;
      en_wait_reg <= 16'(EN_CYC);
    end
    else
    begin
      if (wr && addr == stp_pkg::ADDR_CTRL)
        en_reg <= wdata[0];
      if (!en_reg)
        en_wait_reg <= 16'(EN_CYC);
      else if (en_wait_reg != 16'h0)
        en_wait_reg <= en_wait_reg - 16'h1;
    end
  end

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      tx_reg    <= '0;
      rx_reg    <= '0;
      bit_reg   <= 6'h0;
      tmr_reg   <= 16'h0;
      sck_reg   <= 1'b0;
      sdi_reg   <= 1'b0;
      csn_reg   <= 1'b1;
    end
    else
    begin
      tmr_reg <= tmr_end ? 16'(HALF_CYC - 1) : tmr_reg - 16'h1;
      unique case (state_reg)
        ST_IDLE:
        begin
          tmr_reg <= 16'(HALF_CYC - 1);
          if (start)
          begin
            tx_reg    <= wdata[BITS-1:0];
            bit_reg   <= 6'h0;
            csn_reg   <= 1'b0;
            state_reg <= ST_LEAD;
          end
        end
        ST_LEAD:
          if (tmr_end)
          begin
            sdi_reg   <= tx_reg[BITS-1];
            tx_reg    <= tx_reg << 1;
            state_reg <= ST_LOW;
          end
        ST_LOW:
          if (tmr_end)
          begin
            sck_reg   <= 1'b1;
            rx_reg    <= {rx_reg[BITS-2:0], sdo_s};
            state_reg <= ST_HIGH;
          end
        ST_HIGH:
          if (tmr_end)
          begin
            sck_reg <= 1'b0;
            bit_reg <= bit_reg + 6'h1;
            if (bit_reg == 6'(BITS - 1))
              state_reg <= ST_TRAIL;
            else
            begin
              sdi_reg   <= tx_reg[BITS-1];
              tx_reg    <= tx_reg << 1;
              state_reg <= ST_LOW;
            end
          end
        ST_TRAIL:
          if (tmr_end)
          begin
            csn_reg   <= 1'b1;
            state_reg <= ST_IDLE;
          end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Completion flag and read port
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      done_reg    <= 1'b0;
      rx_word_reg <= '0;
      rdata       <= 32'h0;
    end
    else
    begin
      if (state_reg == ST_TRAIL && tmr_end)
      begin
        done_reg    <= 1'b1;
        rx_word_reg <= rx_reg;
      end
      else if (wr && addr == stp_pkg::ADDR_STAT && wdata[stp_pkg::STAT_DONE])
        done_reg <= 1'b0;
      rdata <= 32'h0;
      if (rd)
        unique case (addr)
          stp_pkg::ADDR_CTRL: rdata <= {31'h0, en_reg};
          stp_pkg::ADDR_STAT: rdata <= {29'h0, en_reg && en_wait_reg == 16'h0, done_reg,
                                        state_reg != ST_IDLE};
          stp_pkg::ADDR_RX:   rdata <= 32'(rx_word_reg);
          default:            rdata <= 32'h0;
        endcase
    end
  end
endmodule : stp_host
`default_nettype wire

// file: tb/stp_link_monitor.sv
/*
  Concurrent checks on the wires of the stepper driver link.
  Assumes one sys_clk domain, a host with HALF_CYC 10, EN_CYC 20 and 12-bit words.
*/
`timescale 1ns/1ps
`default_nettype none
module stp_link_monitor (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic chip_select_n,
  input wire logic device_enable_n,
  input wire logic sdo_line
);
  logic       sck_d_reg;
  logic [3:0] edge_cnt_reg;

  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ------------------------------------------------------------
  // Serial clock rises counted within one frame, saturating.
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_d_reg    <= 1'b0;
      edge_cnt_reg <= 4'h0;
    end
    else
    begin
      sck_d_reg <= sck;
      if (chip_select_n)
        edge_cnt_reg <= 4'h0;
      else if (sck && !sck_d_reg && edge_cnt_reg != 4'hF)
        edge_cnt_reg <= edge_cnt_reg + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // Properties.
  // ------------------------------------------------------------
  sequence s_select;
    $fell(chip_select_n);
  endsequence

  sequence s_enable;
    $fell(device_enable_n);
  endsequence

  a_sdo_off_deselect: assert property (chip_select_n [*5] |-> !sdo_oe)
    else $error("data out driven while deselected");
  a_sdo_off_disable: assert property (device_enable_n [*5] |-> !sdo_oe)
    else $error("data out driven while disabled");
  a_sdo_oe_select: assert property ($rose(sdo_oe) |-> !chip_select_n && !device_enable_n)
    else $error("data out enabled outside a frame");
  a_sdo_hold_high: assert property (sdo_oe && $past(sdo_oe) && sck && $past(sck)
    |-> $stable(sdo))
    else $error("data out moved while serial clock high");
  a_sdi_hold_high: assert property (sck |-> $stable(sdi))
    else $error("data in moved while serial clock high");
  a_sck_idle_low: assert property (chip_select_n |-> !sck)
    else $error("serial clock active outside a frame");
  a_frame_lead: assert property (s_select |-> !sck [*8])
    else $error("serial clock too soon after select");
  a_twelve_edges: assert property ($rose(chip_select_n) |-> edge_cnt_reg == 4'hC)
    else $error("frame closed without twelve clocks");
  a_enable_held: assert property (!chip_select_n |-> !device_enable_n)
    else $error("frame while device disabled");
  a_enable_lead: assert property (s_enable |-> chip_select_n [*8])
    else $error("frame too soon after enable");
endmodule : stp_link_monitor
`default_nettype wire

// file: tb/stepper_driver_serial_control_tb.sv
/*
  Self-checking bench: a 12-bit host/device pair and a 16-bit chained pair on one bus.
  Assumes the register map and timing of the design hand-over; no other models.
*/
`timescale 1ns/1ps
`default_nettype none
module stepper_driver_serial_control_tb;
  typedef struct packed {
    logic [15:0] w;
    logic [2:0]  ld;
    logic        ot;
    logic        pw;
    logic        vs;
    logic [11:0] st;
  } stp_row_type;

  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [2:0]  ld_in = 3'h0;
  logic        ot_in = 1'b0;
  logic        pw_in = 1'b0;
  logic        vs_in = 1'b0;
  logic        vcc_in = 1'b0;
  logic        pwm_tick = 1'b0;
  logic [2:0]  oc_hit = 3'h0;
  logic        osc_tick = 1'b0;
  logic [1:0]  pwm_off = 2'h0;
  logic [31:0] rdata;
  logic [31:0] rdata2;
  wire logic [11:0] cmd1;
  wire logic [11:0] cmd2;
  wire logic [4:0]  st1;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc_count = 0;
  stp_row_type rows [5] = '{'{16'hAFFF, 3'h7, 1'b0, 1'b0, 1'b0, 12'hF00},
    '{16'h5842, 3'h3, 1'b0, 1'b0, 1'b1, 12'h72C},
    '{16'h3000, 3'h5, 1'b1, 1'b1, 1'b0, 12'hBC8},
    '{16'hC021, 3'h6, 1'b0, 1'b1, 1'b0, 12'hD40},
    '{16'h0A5A, 3'h2, 1'b0, 1'b0, 1'b1, 12'h520}};

  stp_link_if lnk_a ();
  stp_link_if lnk_b ();
  stp_host #(.EN_CYC(20)) stp_host_i (.sys_clk(sys_clk), .resetn(resetn), .lnk(lnk_a),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  stp_host #(.BITS(16), .EN_CYC(20)) stp_host_i2 (.sys_clk(sys_clk), .resetn(resetn),
    .lnk(lnk_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata2));
  stp_device stp_device_i (.sys_clk(sys_clk), .resetn(resetn), .lnk(lnk_a),
    .load_level_in(ld_in), .overtemp_in(ot_in), .prewarn_in(pw_in), .vs_low_in(vs_in),
    .vcc_low_in(vcc_in), .pwm_tick(pwm_tick), .oc_hit(oc_hit), .osc_tick(osc_tick),
    .pwm_off(pwm_off), .mixed_decay_a(cmd1[11]), .coil_current_a(cmd1[10:7]),
    .bridge_a_direction(cmd1[6]), .mixed_decay_b(cmd1[5]), .coil_current_b(cmd1[4:1]),
    .bridge_b_direction(cmd1[0]), .chopper_on(st1[1:0]), .gate_drive_en(st1[3]),
    .osc_enable(st1[2]), .standby(st1[4]));
  stp_device stp_device_i2 (.sys_clk(sys_clk), .resetn(resetn), .lnk(lnk_b),
    .load_level_in(ld_in), .overtemp_in(ot_in), .prewarn_in(pw_in), .vs_low_in(vs_in),
    .vcc_low_in(vcc_in), .pwm_tick(pwm_tick), .oc_hit(oc_hit), .osc_tick(osc_tick),
    .pwm_off(pwm_off), .mixed_decay_a(cmd2[11]), .coil_current_a(cmd2[10:7]),
    .bridge_a_direction(cmd2[6]), .mixed_decay_b(cmd2[5]), .coil_current_b(cmd2[4:1]),
    .bridge_b_direction(cmd2[0]), .chopper_on(), .gate_drive_en(), .osc_enable(),
    .standby());
  stp_link_monitor stp_link_monitor_i (.sys_clk(sys_clk), .resetn(resetn),
    .sck(lnk_a.sck), .sdi(lnk_a.sdi), .sdo(lnk_a.sdo), .sdo_oe(lnk_a.sdo_oe),
    .chip_select_n(lnk_a.chip_select_n), .device_enable_n(lnk_a.device_enable_n),
    .sdo_line(lnk_a.sdo_line));

  always #5 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // Helpers.
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge sys_clk)
  begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 30000)
    begin
      err_total = err_total + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    if (seen !== exp)
      err_total = err_total + 1;
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_reg(input logic [3:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1;
  endtask : rd_reg

  function automatic logic [4:0] stb_exp(input logic [11:0] c);
    logic sb;
    sb = (c[10:7] == 4'h0) && (c[4:1] == 4'h0);
    return {sb, !sb, !sb, c[4:1] != 4'h0, c[10:7] != 4'h0};
  endfunction : stb_exp

  task automatic xfer(input logic [15:0] w, input logic [11:0] st);
    int n;
    wr_reg(stp_pkg::ADDR_CMD, {16'h0, w});
    n = 0;
    do
    begin
      rd_reg(stp_pkg::ADDR_STAT);
      n = n + 1;
    end
    while (!(rdata[stp_pkg::STAT_DONE] === 1'b1 && rdata2[stp_pkg::STAT_DONE] === 1'b1)
           && n < 400);
    chk({rdata[stp_pkg::STAT_DONE], rdata2[stp_pkg::STAT_DONE]}, 32'h3);
    wr_reg(stp_pkg::ADDR_STAT, 32'h2);
    rd_reg(stp_pkg::ADDR_RX);
    chk(rdata[11:0], st);
    chk(rdata2[15:0], {st, w[15:12]});
    repeat (10) @(posedge sys_clk);
    chk(cmd1, w[11:0]);
    chk(cmd2, w[11:0]);
    chk(st1, stb_exp(w[11:0]));
  endtask : xfer

  task automatic pulse_pwm(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      pwm_tick <= 1'b1;
      oc_hit   <= 3'h7;
      @(posedge sys_clk);
      pwm_tick <= 1'b0;
      oc_hit   <= 3'h0;
    end
  endtask : pulse_pwm

  task automatic pulse_osc(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      osc_tick <= 1'b1;
      @(posedge sys_clk);
      osc_tick <= 1'b0;
    end
  endtask : pulse_osc

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk(cmd1, 12'h000);
    chk(st1, 5'h10);
    chk(lnk_a.sdo_line, 1'b1);
    rd_reg(stp_pkg::ADDR_STAT);
    chk(rdata, 32'h0);
    rd_reg(4'h2);
    chk(rdata, 32'h0);
    $display("test reset done");
    wr_reg(stp_pkg::ADDR_CTRL, 32'h1);
    repeat (30) @(posedge sys_clk);
    rd_reg(stp_pkg::ADDR_STAT);
    chk(rdata, 32'h4);
    foreach (rows[i])
    begin
      ld_in <= rows[i].ld;
      ot_in <= rows[i].ot;
      pw_in <= rows[i].pw;
      vs_in <= rows[i].vs;
      xfer(rows[i].w, rows[i].st);
    end
    $display("test table done");
    vs_in <= 1'b0;
    ld_in <= 3'h0;
    pw_in <= 1'b0;
    pulse_pwm(2);
    xfer(16'h0A5A, 12'h100);
    pulse_pwm(5);
    xfer(16'h0A5A, 12'h11F);
    xfer(16'h0000, 12'h11F);
    xfer(16'h0A5A, 12'h100);
    $display("test overcurrent done");
    pulse_osc(15);
    xfer(16'h0A5A, 12'h10C);
    @(posedge sys_clk);
    pwm_off <= 2'h3;
    @(posedge sys_clk);
    pwm_off <= 2'h0;
    pulse_osc(14);
    xfer(16'h0A5A, 12'h100);
    pulse_osc(1);
    xfer(16'h0A5A, 12'h10C);
    $display("test open load done");
    vcc_in <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk(st1, 5'h10);
    vcc_in <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk(st1, stb_exp(12'hA5A));
    wr_reg(stp_pkg::ADDR_CTRL, 32'h0);
    repeat (10) @(posedge sys_clk);
    chk(cmd1, 12'h000);
    chk(st1, 5'h10);
    $display("test standby done");
    tally_and_finish();
  end
endmodule : stepper_driver_serial_control_tb
`default_nettype wire
